// file: logic/flm_top.sv
// Functional notes
// - Torch force input high selects torch operation.
// - Torch force honoured only in shutdown or voltage.
// - Each sink enabled by its own field bit.
// - Voltage force selects voltage mode at 4.95 V.
// - Strobe low gives torch level, high flash level.
// - Multipurpose pin: GPIO or PG; default open-drain PG.
// - High-current select: direct drive or storage mode.
// - Master reset low: shutdown, interface reset.
// - Transmit mask drops flash to torch level immediately.
// - Control interface up to 3.4 Mbit/s, host respects it.
//
// The register offsets and register access over Wishbone were left to the implementer.
`include "flm_defines.svh"
`default_nettype none
module flm_top (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Hardware control pins.
  input  wire logic        torch_force_input,
  input  wire logic        voltage_mode_force_input,
  input  wire logic        flash_strobe_input,
  input  wire logic        tx_mask_input,
  input  wire logic        high_current_select,
  input  wire logic        master_reset_n,
  input  wire logic        output_in_regulation_flag,
  // Multipurpose pin.
  input  wire logic        multipurpose_pin_i,
  output logic             multipurpose_pin_o,
  output logic             multipurpose_pin_oe,
  // Power stage and sink controls.
  output logic             sink_one_en,
  output logic             sink_two_en,
  output logic             sink_three_en,
  output logic      [2:0]  led_level,
  output logic      [3:0]  vout_target,
  output logic      [3:0]  mode_state,
  output logic             power_stage_en,
  output logic             power_stage_reduced,
  // Interrupt.
  output logic             irq
);
  // Address decode used by both the write and the read paths.
  function automatic logic flm_hit(input logic [7:0] adr,
                                   input logic [7:0] off);
    flm_hit = (adr[7:2] == off[7:2]);
  endfunction : flm_hit

  logic [`FLM_PIN_W-1:0] pin_raw;
  logic [`FLM_PIN_W-1:0] pin_s;
  logic                  torch_s;
  logic                  volt_s;
  logic                  strobe_s;
  logic                  mask_s;
  logic                  hcs_s;
  logic                  nrst_s;
  logic                  pg_s;
  logic                  gpi_s;
  logic                  regs_clr;

  // Every pin passes the three-stage filter before any decision.
  assign pin_raw = {multipurpose_pin_i, output_in_regulation_flag,
                    master_reset_n, high_current_select, tx_mask_input,
                    flash_strobe_input, voltage_mode_force_input,
                    torch_force_input};
  flm_sync #(
    .WIDTH (`FLM_PIN_W),
    .RST_V (`FLM_PIN_RST)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    (pin_raw),
    .q    (pin_s)
  );
  assign torch_s  = pin_s[`FLM_PIN_TORCH];
  assign volt_s   = pin_s[`FLM_PIN_VOLT];
  assign strobe_s = pin_s[`FLM_PIN_STRB];
  assign mask_s   = pin_s[`FLM_PIN_TXM];
  assign hcs_s    = pin_s[`FLM_PIN_HCS];
  assign nrst_s   = pin_s[`FLM_PIN_NRST];
  assign pg_s     = pin_s[`FLM_PIN_PG];
  assign gpi_s    = pin_s[`FLM_PIN_GPI];
  // The master reset pin clears the register interface like rst does.
  assign regs_clr = rst || !nrst_s;

  // Bus request qualifiers; ack comes one cycle after the request.
  logic wb_req;
  logic wb_wr;
  logic ack_reg;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_wr  = wb_req && wb_we_i;

  // Software state.
  logic [2:0]         sink_reg;
  flm_pkg::flm_prog_t prog_reg;
  logic               hcdis_reg;
  logic [2:0]         torch_lvl_reg;
  logic [2:0]         strb_lvl_reg;
  logic [3:0]         vout_prog_reg;
  flm_pkg::flm_mpp_t  mpp_cfg_reg;
  logic               gpo_reg;
  logic               goe_reg;

  // Control, level and pin registers; only byte lanes 0 and 1 exist.
  always_ff @(posedge mclk) begin
    if (regs_clr) begin
      sink_reg      <= `FLM_SINK_RST;
      prog_reg      <= flm_pkg::PROG_SHUT;
      hcdis_reg     <= 1'b0;
      torch_lvl_reg <= `FLM_TORCH_RST;
      strb_lvl_reg  <= `FLM_STRB_RST;
      vout_prog_reg <= `FLM_VOUT_RST;
      mpp_cfg_reg   <= flm_pkg::MPP_PG_OD;
      gpo_reg       <= 1'b0;
      goe_reg       <= 1'b0;
    end else if (wb_wr) begin
      if (flm_hit(wb_adr_i, `FLM_ADR_CTRL) && wb_sel_i[0]) begin
        sink_reg  <= wb_dat_i[`FLM_SINK_MSB:`FLM_SINK_LSB];
        prog_reg  <= flm_pkg::flm_prog_t'(
                       wb_dat_i[`FLM_MODE_MSB:`FLM_MODE_LSB]);
        hcdis_reg <= wb_dat_i[`FLM_HCDIS_BIT];
      end
      if (flm_hit(wb_adr_i, `FLM_ADR_LEVEL)) begin
        if (wb_sel_i[0]) begin
          torch_lvl_reg <= wb_dat_i[`FLM_TORCH_MSB:`FLM_TORCH_LSB];
          strb_lvl_reg  <= wb_dat_i[`FLM_STRB_MSB:`FLM_STRB_LSB];
        end
        if (wb_sel_i[1]) begin
          vout_prog_reg <= wb_dat_i[`FLM_VOUT_MSB:`FLM_VOUT_LSB];
        end
      end
      if (flm_hit(wb_adr_i, `FLM_ADR_MPP) && wb_sel_i[0]) begin
        mpp_cfg_reg <= flm_pkg::flm_mpp_t'(
                         wb_dat_i[`FLM_MPP_MSB:`FLM_MPP_LSB]);
        gpo_reg     <= wb_dat_i[`FLM_GPO_BIT];
        goe_reg     <= wb_dat_i[`FLM_GOE_BIT];
      end
    end
  end

  // Effective mode, current level and output target.
  flm_pkg::flm_mode_t mode_next;
  flm_pkg::flm_mode_t mode_reg;
  logic [2:0]         level_next;
  logic [3:0]         vout_next;
  logic               flash_hi;
  logic               torch_ok;
  always_comb begin
    mode_next = flm_pkg::MODE_SHUT;
    vout_next = vout_prog_reg;
    torch_ok  = (prog_reg == flm_pkg::PROG_SHUT) ||
                (prog_reg == flm_pkg::PROG_VOLT);
    if (!nrst_s) begin
      mode_next = flm_pkg::MODE_SHUT;
    end else if (torch_s && torch_ok) begin
      mode_next = flm_pkg::MODE_TORCH;
    end else if (volt_s) begin
      mode_next = flm_pkg::MODE_VOLT;
      vout_next = `FLM_VOUT_495;
    end else begin
      case (prog_reg)
        flm_pkg::PROG_SHUT:  mode_next = flm_pkg::MODE_SHUT;
        flm_pkg::PROG_VOLT:  mode_next = flm_pkg::MODE_VOLT;
        flm_pkg::PROG_TORCH: mode_next = flm_pkg::MODE_TORCH;
        flm_pkg::PROG_FLASH: mode_next = flm_pkg::MODE_FLASH;
        default:             mode_next = flm_pkg::MODE_SHUT;
      endcase
    end
    // The mask is a plain gate on the strobe, so it adds no cycle.
    flash_hi   = (mode_next == flm_pkg::MODE_FLASH) && strobe_s &&
                 !mask_s;
    level_next = flash_hi ? strb_lvl_reg : torch_lvl_reg;
  end

  // Driver outputs, all registered.
  logic [2:0] sink_out_reg;
  logic [2:0] level_reg;
  logic [3:0] vout_reg;
  logic       flash_hi_reg;
  logic       ps_en_reg;
  logic       ps_red_reg;
  logic       lit;
  assign lit = (mode_next == flm_pkg::MODE_TORCH) ||
               (mode_next == flm_pkg::MODE_FLASH);
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg     <= flm_pkg::MODE_SHUT;
      sink_out_reg <= 3'h0;
      level_reg    <= 3'h0;
      vout_reg     <= 4'h0;
      flash_hi_reg <= 1'b0;
      ps_en_reg    <= 1'b0;
      ps_red_reg   <= 1'b0;
    end else begin
      mode_reg     <= mode_next;
      sink_out_reg <= lit ? sink_reg : 3'h0;
      level_reg    <= level_next;
      vout_reg     <= vout_next;
      flash_hi_reg <= flash_hi;
      // Storage mode unloads the stage during flash; hcdis picks off.
      ps_en_reg    <= (mode_next != flm_pkg::MODE_SHUT) &&
                      !(hcs_s && flash_hi && hcdis_reg);
      ps_red_reg   <= hcs_s && flash_hi && !hcdis_reg;
    end
  end

  // Multipurpose pin drive; open-drain PG only ever pulls low.
  logic mpp_o_reg;
  logic mpp_oe_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      mpp_o_reg  <= 1'b0;
      mpp_oe_reg <= 1'b0;
    end else begin
      case (mpp_cfg_reg)
        flm_pkg::MPP_PG_OD: begin
          mpp_o_reg  <= 1'b0;
          mpp_oe_reg <= !pg_s;
        end
        flm_pkg::MPP_PG_PP: begin
          mpp_o_reg  <= pg_s;
          mpp_oe_reg <= 1'b1;
        end
        flm_pkg::MPP_GPIO: begin
          mpp_o_reg  <= gpo_reg;
          mpp_oe_reg <= goe_reg;
        end
        default: begin
          mpp_o_reg  <= 1'b0;
          mpp_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Events and interrupt; a new event beats a write-one-to-clear.
  logic [`FLM_EV_W-1:0] ev;
  logic [`FLM_EV_W-1:0] irq_stat_reg;
  logic [`FLM_EV_W-1:0] irq_mask_reg;
  logic                 mask_hit_reg;
  logic                 pg_prev_reg;
  logic                 irq_reg;
  always_comb begin
    ev                = '0;
    ev[`FLM_EV_FLASH] = flash_hi && !flash_hi_reg;
    ev[`FLM_EV_MASK]  = (mode_next == flm_pkg::MODE_FLASH) && strobe_s &&
                        mask_s && !mask_hit_reg;
    ev[`FLM_EV_TORCH] = (mode_next == flm_pkg::MODE_TORCH) &&
                        (mode_reg != flm_pkg::MODE_TORCH) && torch_s;
    ev[`FLM_EV_PGLOST] = pg_prev_reg && !pg_s;
  end
  always_ff @(posedge mclk) begin
    if (regs_clr) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      mask_hit_reg <= 1'b0;
      pg_prev_reg  <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      mask_hit_reg <= (mode_next == flm_pkg::MODE_FLASH) && strobe_s &&
                      mask_s;
      pg_prev_reg  <= pg_s;
      if (wb_wr && wb_sel_i[0] && flm_hit(wb_adr_i, `FLM_ADR_IRQS)) begin
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[`FLM_EV_W-1:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
      if (wb_wr && wb_sel_i[0] && flm_hit(wb_adr_i, `FLM_ADR_IRQM)) begin
        irq_mask_reg <= wb_dat_i[`FLM_EV_W-1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read mux; the register block stands in for the serial port.
  logic [31:0] rd_next;
  logic [31:0] rd_reg;
  always_comb begin
    rd_next = 32'h0000_0000;
    if (flm_hit(wb_adr_i, `FLM_ADR_CTRL)) begin
      rd_next[`FLM_SINK_MSB:`FLM_SINK_LSB] = sink_reg;
      rd_next[`FLM_MODE_MSB:`FLM_MODE_LSB] = prog_reg;
      rd_next[`FLM_HCDIS_BIT]              = hcdis_reg;
    end else if (flm_hit(wb_adr_i, `FLM_ADR_LEVEL)) begin
      rd_next[`FLM_TORCH_MSB:`FLM_TORCH_LSB] = torch_lvl_reg;
      rd_next[`FLM_STRB_MSB:`FLM_STRB_LSB]   = strb_lvl_reg;
      rd_next[`FLM_VOUT_MSB:`FLM_VOUT_LSB]   = vout_prog_reg;
    end else if (flm_hit(wb_adr_i, `FLM_ADR_MPP)) begin
      rd_next[`FLM_MPP_MSB:`FLM_MPP_LSB] = mpp_cfg_reg;
      rd_next[`FLM_GPO_BIT]              = gpo_reg;
      rd_next[`FLM_GOE_BIT]              = goe_reg;
      rd_next[`FLM_GPI_BIT]              = gpi_s;
    end else if (flm_hit(wb_adr_i, `FLM_ADR_STAT)) begin
      rd_next[3:0]  = mode_reg;
      rd_next[6:4]  = level_reg;
      rd_next[11:8] = vout_reg;
      rd_next[23:16] = pin_s;
    end else if (flm_hit(wb_adr_i, `FLM_ADR_IRQS)) begin
      rd_next[`FLM_EV_W-1:0] = irq_stat_reg;
    end else if (flm_hit(wb_adr_i, `FLM_ADR_IRQM)) begin
      rd_next[`FLM_EV_W-1:0] = irq_mask_reg;
    end
  end
  // Bus answer; the slave answers only rst, so access stays possible.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rd_reg  <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      rd_reg  <= (wb_req && !wb_we_i) ? rd_next : 32'h0000_0000;
    end
  end

  assign wb_ack_o            = ack_reg;
  assign wb_dat_o            = rd_reg;
  assign sink_one_en         = sink_out_reg[0];
  assign sink_two_en         = sink_out_reg[1];
  assign sink_three_en       = sink_out_reg[2];
  assign led_level           = level_reg;
  assign vout_target         = vout_reg;
  assign mode_state          = mode_reg;
  assign power_stage_en      = ps_en_reg;
  assign power_stage_reduced = ps_red_reg;
  assign multipurpose_pin_o  = mpp_o_reg;
  assign multipurpose_pin_oe = mpp_oe_reg;
  assign irq                 = irq_reg;

  // Checks on the mode, current and multipurpose pin logic.
  property p_torch_force;
    @(posedge mclk) disable iff (rst)
    nrst_s && torch_s && prog_reg == flm_pkg::PROG_SHUT
      |=> mode_state == flm_pkg::MODE_TORCH;
  endproperty
  a_torch_force: assert property (p_torch_force)
    else $error("torch force did not select torch mode");
  property p_torch_ignored;
    @(posedge mclk) disable iff (rst)
    nrst_s && !volt_s && prog_reg == flm_pkg::PROG_FLASH
      |=> mode_state == flm_pkg::MODE_FLASH;
  endproperty
  a_torch_ignored: assert property (p_torch_ignored)
    else $error("flash mode left under a force input");
  property p_sinks;
    @(posedge mclk) disable iff (rst)
    ##1 (mode_state == flm_pkg::MODE_TORCH ||
         mode_state == flm_pkg::MODE_FLASH)
      |-> {sink_three_en, sink_two_en, sink_one_en} == $past(sink_reg);
  endproperty
  a_sinks: assert property (p_sinks)
    else $error("sink enables differ from field");
  property p_volt_force;
    @(posedge mclk) disable iff (rst)
    nrst_s && volt_s && !torch_s
      |=> vout_target == `FLM_VOUT_495 &&
          mode_state != flm_pkg::MODE_SHUT;
  endproperty
  a_volt_force: assert property (p_volt_force)
    else $error("voltage force target wrong");
  property p_flash_level;
    @(posedge mclk) disable iff (rst)
    nrst_s && !volt_s && prog_reg == flm_pkg::PROG_FLASH &&
    strobe_s && !mask_s
      |=> led_level == $past(strb_lvl_reg) && flash_hi_reg;
  endproperty
  a_flash_level: assert property (p_flash_level)
    else $error("strobe level not applied");
  property p_mpp_default;
    @(posedge mclk) disable iff (rst)
    $past(rst) |-> mpp_cfg_reg == flm_pkg::MPP_PG_OD && !mpp_oe_reg;
  endproperty
  a_mpp_default: assert property (p_mpp_default)
    else $error("pin not open-drain power good after reset");
  property p_storage;
    @(posedge mclk) disable iff (rst)
    hcs_s && flash_hi |=> !power_stage_en || power_stage_reduced;
  endproperty
  a_storage: assert property (p_storage)
    else $error("full power stage during storage flash");
  property p_master_reset;
    @(posedge mclk) disable iff (rst)
    !nrst_s |=> mode_state == flm_pkg::MODE_SHUT &&
                prog_reg == flm_pkg::PROG_SHUT && irq_mask_reg == '0;
  endproperty
  a_master_reset: assert property (p_master_reset)
    else $error("master reset did not force shutdown");
  property p_tx_mask;
    @(posedge mclk) disable iff (rst)
    nrst_s && prog_reg == flm_pkg::PROG_FLASH && strobe_s && mask_s
      |=> led_level == $past(torch_lvl_reg) && !flash_hi_reg;
  endproperty
  a_tx_mask: assert property (p_tx_mask)
    else $error("transmit mask did not drop to torch level");
endmodule : flm_top
`default_nettype wire

// file: logic/flm_defines.svh
`ifndef FLM_DEFINES_SVH
`define FLM_DEFINES_SVH
// Register byte offsets on the Wishbone slave.
`define FLM_ADR_CTRL   8'h00
`define FLM_ADR_LEVEL  8'h04
`define FLM_ADR_MPP    8'h08
`define FLM_ADR_STAT   8'h0C
`define FLM_ADR_IRQS   8'h10
`define FLM_ADR_IRQM   8'h14
// Control register fields.
`define FLM_SINK_LSB   1
`define FLM_SINK_MSB   3
`define FLM_MODE_LSB   4
`define FLM_MODE_MSB   5
`define FLM_HCDIS_BIT  6
// Level register fields.
`define FLM_TORCH_LSB  0
`define FLM_TORCH_MSB  2
`define FLM_STRB_LSB   4
`define FLM_STRB_MSB   6
`define FLM_VOUT_LSB   8
`define FLM_VOUT_MSB   11
// Multipurpose pin register fields.
`define FLM_MPP_LSB    0
`define FLM_MPP_MSB    1
`define FLM_GPO_BIT    4
`define FLM_GOE_BIT    5
`define FLM_GPI_BIT    8
// Reset values.
`define FLM_SINK_RST   3'h7
`define FLM_TORCH_RST  3'h0
`define FLM_STRB_RST   3'h0
`define FLM_VOUT_RST   4'h0
// Output target code that stands for a fixed 4.95 V.
`define FLM_VOUT_495   4'h6
// Event bits of the interrupt status and mask registers.
`define FLM_EV_W       4
`define FLM_EV_FLASH   0
`define FLM_EV_MASK    1
`define FLM_EV_TORCH   2
`define FLM_EV_PGLOST  3
// Pin positions inside the synchroniser vector.
`define FLM_PIN_W      8
`define FLM_PIN_TORCH  0
`define FLM_PIN_VOLT   1
`define FLM_PIN_STRB   2
`define FLM_PIN_TXM    3
`define FLM_PIN_HCS    4
`define FLM_PIN_NRST   5
`define FLM_PIN_PG     6
`define FLM_PIN_GPI    7
`define FLM_PIN_RST    8'h00
`endif

// file: logic/flm_pkg.sv
`default_nettype none
package flm_pkg;
  // Effective operating mode, one-hot.
  typedef enum logic [3:0] {
    MODE_SHUT  = 4'h1,
    MODE_VOLT  = 4'h2,
    MODE_TORCH = 4'h4,
    MODE_FLASH = 4'h8
  } flm_mode_t;
  // Mode as programmed by software.
  typedef enum logic [1:0] {
    PROG_SHUT  = 2'h0,
    PROG_VOLT  = 2'h1,
    PROG_TORCH = 2'h2,
    PROG_FLASH = 2'h3
  } flm_prog_t;
  // Function of the multipurpose pin.
  typedef enum logic [1:0] {
    MPP_PG_OD = 2'h0,
    MPP_PG_PP = 2'h1,
    MPP_GPIO  = 2'h2
  } flm_mpp_t;
endpackage : flm_pkg
`default_nettype wire

// file: logic/flm_sync.sv
`default_nettype none
module flm_sync #(
  parameter int          WIDTH = 8,
  parameter logic [7:0]  RST_V = 8'h00
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst,
  // Asynchronous inputs and their filtered copies.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  // A change is taken only once the second and third stages agree, so a
  // single metastable sample never reaches the mode logic.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      always_ff @(posedge mclk) begin
        if (rst) begin
          s1_reg <= RST_V[i];
          s2_reg <= RST_V[i];
          s3_reg <= RST_V[i];
          q_reg  <= RST_V[i];
        end else begin
          s1_reg <= d[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign q[i] = q_reg;
    end
  endgenerate
endmodule : flm_sync
`default_nettype wire

// file: tb/flm_pins_model.sv
`default_nettype none
module flm_pins_model (
  // Clock.
  input  wire logic mclk,
  // Commands from the bench.
  input  wire logic strobe_cmd,
  input  wire logic mask_cmd,
  input  wire logic hcs_cmd,
  // Pins toward the block.
  output logic      flash_strobe_input,
  output logic      tx_mask_input,
  output logic      high_current_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // The select pin is driven from time zero so it never floats.
  initial begin
    flash_strobe_input  = 1'b0;
    tx_mask_input       = 1'b0;
    high_current_select = 1'b0;
    // Camera strobe and radio mask move just after an edge, like real logic.
    forever begin
      @(posedge mclk);
      flash_strobe_input  <= strobe_cmd;
      tx_mask_input       <= mask_cmd;
      high_current_select <= hcs_cmd;
    end
  end
endmodule : flm_pins_model
`default_nettype wire

// file: tb/flm_top_tb.sv
`include "flm_defines.svh"
`default_nettype none
module flm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic        tf, vf, strobe_cmd, mask_cmd, hcs_cmd, fs, txm, hcs;
  logic        nrst, pg, mpp_o, mpp_oe, s1, s2, s3, ps_en, ps_red, irq;
  logic [2:0]  led_level;
  logic [3:0]  vout_target, mode_state;
  wire logic   mpp_i;
  int          mismatches = 0;
  int          num_checks = 0;
  logic [31:0] rng = 32'h9854B7F2;

  // The pin has a pull-up, so a released pin reads high.
  assign mpp_i = mpp_oe ? mpp_o : 1'b1;

  flm_pins_model flm_pins_model_i (.mclk(mclk), .strobe_cmd(strobe_cmd),
    .mask_cmd(mask_cmd), .hcs_cmd(hcs_cmd), .flash_strobe_input(fs),
    .tx_mask_input(txm), .high_current_select(hcs));

  flm_top flm_top_i (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .torch_force_input(tf),
    .voltage_mode_force_input(vf), .flash_strobe_input(fs),
    .tx_mask_input(txm), .high_current_select(hcs),
    .master_reset_n(nrst), .output_in_regulation_flag(pg),
    .multipurpose_pin_i(mpp_i), .multipurpose_pin_o(mpp_o),
    .multipurpose_pin_oe(mpp_oe), .sink_one_en(s1), .sink_two_en(s2),
    .sink_three_en(s3), .led_level(led_level), .vout_target(vout_target),
    .mode_state(mode_state), .power_stage_en(ps_en),
    .power_stage_reduced(ps_red), .irq(irq));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Xorshift keeps the random stream repeatable across runs.
  function logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  // Pin forcing beats the programmed mode; torch force only from shut/volt.
  function logic [3:0] exp_mode(input logic [1:0] pm, input logic t,
                                input logic v);
    if (t && pm <= 2'h1) return 4'h4;
    if (v) return 4'h2;
    return 4'h1 << pm;
  endfunction : exp_mode

  // The mask wins over the strobe, so flash level needs strobe and no mask.
  function logic [2:0] exp_lvl(input logic s, input logic m,
                               input logic [2:0] t, input logic [2:0] f);
    return (s && !m) ? f : t;
  endfunction : exp_lvl

  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task chk_pin(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  // One classic cycle; request held until ack is seen at a rising edge.
  task wb_acc(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_sel   <= 4'hF;
    wb_dat_w <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    if (wb_ack !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t bus gave no ack", $time);
    end
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_acc

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_acc(1'b1, a, d, q);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_acc(1'b0, a, 32'h0, q);
    chk_reg(q, e);
  endtask : rdc

  // Pins pass a filter; eight cycles covers it with margin.
  task drv(input logic t, input logic v, input logic s, input logic m);
    @(posedge mclk);
    tf         <= t;
    vf         <= v;
    strobe_cmd <= s;
    mask_cmd   <= m;
    repeat (8) @(posedge mclk);
  endtask : drv

  // Watchdog: the whole sequence needs well under this many cycles.
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    report_and_stop();
  end

  // Pin function table: config, power-good level, expected {oe, o}.
  logic [31:0] mcfg [7] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h32, 32'h2, 32'h33};
  logic        mpg  [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [1:0]  moe  [7] = '{2'b00, 2'b10, 2'b11, 2'b10, 2'b11, 2'b00, 2'b00};

  initial begin
    int          i, n1, n2;
    logic [2:0]  t, f;
    logic [3:0]  v;
    logic [1:0]  pm;
    logic [31:0] r;
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, tf, vf} = 5'h00;
    {strobe_cmd, mask_cmd, hcs_cmd} = 3'h0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0;
    nrst = 1'b1;
    pg = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    rdc(`FLM_ADR_CTRL, 32'hE);
    rdc(`FLM_ADR_LEVEL, 32'h0);
    chk_pin(mode_state, 4'h1);
    wr(8'h1C, 32'hFFFFFFFF);
    rdc(8'h1C, 32'h0);
    // The first entry leaves the pin unwritten to see its default.
    for (i = 0; i < 7; i++) begin
      if (i > 0) wr(`FLM_ADR_MPP, mcfg[i]);
      @(posedge mclk);
      pg <= mpg[i];
      repeat (8) @(posedge mclk);
      chk_pin({2'b0, mpp_oe, mpp_oe & mpp_o}, {2'b0, moe[i]});
      rdc(`FLM_ADR_MPP, mcfg[i] | {23'h0, moe[i][1] ? moe[i][0] : 1'b1,
          8'h0});
    end
    wr(`FLM_ADR_MPP, 32'h0);
    pg <= 1'b1;
    // Every sink pattern under torch forcing, even patterns from shut and odd ones from volt.
    for (i = 0; i < 8; i++) begin
      pm = {1'b0, i[0]};
      wr(`FLM_ADR_CTRL, {26'h0, pm, i[2:0], 1'b0});
      drv(1'b1, 1'b0, 1'b0, 1'b0);
      chk_pin(mode_state, exp_mode(pm, 1'b1, 1'b0));
      chk_pin({1'b0, s3, s2, s1}, {1'b0, i[2:0]});
      drv(1'b0, 1'b0, 1'b0, 1'b0);
      chk_pin(mode_state, exp_mode(pm, 1'b0, 1'b0));
      chk_pin({1'b0, s3, s2, s1}, 4'h0);
    end
    // Voltage forcing overrides any programmed target code.
    for (i = 0; i < 3; i++) begin
      r = rnd();
      v = (r[3:0] == 4'h6) ? 4'h7 : r[3:0];
      pm = i[1:0];
      wr(`FLM_ADR_LEVEL, {20'h0, v, 8'h0});
      wr(`FLM_ADR_CTRL, {26'h0, pm, 4'hE});
      drv(1'b0, 1'b1, 1'b0, 1'b0);
      chk_pin(mode_state, 4'h2);
      chk_pin(vout_target, `FLM_VOUT_495);
      drv(1'b0, 1'b0, 1'b0, 1'b0);
      chk_pin(mode_state, exp_mode(pm, 1'b0, 1'b0));
      if (pm == 2'h1) chk_pin(vout_target, v);
    end
    // Random strobe, mask and torch force in programmed flash mode.
    for (i = 0; i < 16; i++) begin
      r = rnd();
      t = r[2:0];
      f = (r[6:4] == t) ? ~t : r[6:4];
      wr(`FLM_ADR_LEVEL, {25'h0, f, 1'b0, t});
      wr(`FLM_ADR_CTRL, 32'h3E);
      drv(r[8], 1'b0, r[9], r[10]);
      chk_pin({1'b0, led_level}, {1'b0, exp_lvl(r[9], r[10], t, f)});
      chk_pin({1'b0, s3, s2, s1}, 4'h7);
    end
    // The mask must pull the level down as fast as the strobe raised it.
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    wr(`FLM_ADR_LEVEL, 32'h52);
    @(posedge mclk);
    strobe_cmd <= 1'b1;
    n1 = 0;
    do begin
      @(posedge mclk);
      n1++;
    end while (led_level !== 3'h5 && n1 < 20);
    @(posedge mclk);
    mask_cmd <= 1'b1;
    n2 = 0;
    do begin
      @(posedge mclk);
      n2++;
    end while (led_level !== 3'h2 && n2 < 20);
    chk_reg(32'(n2), 32'(n1));
    chk_pin({1'b0, led_level}, 4'h2);
    drv(1'b0, 1'b0, 1'b1, 1'b0);
    // Storage mode with and without the power stage disabled in flash.
    for (i = 0; i < 4; i++) begin
      wr(`FLM_ADR_CTRL, 32'h3E | {25'h0, i[1], 6'h0});
      @(posedge mclk);
      hcs_cmd <= i[0];
      repeat (8) @(posedge mclk);
      chk_pin({2'b0, ps_en, ps_red},
              {2'b0, !(i[0] & i[1]), i[0] & !i[1]});
    end
    hcs_cmd <= 1'b0;
    // Torch-forced event: raise, mask off, mask on, clear.
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    wr(`FLM_ADR_CTRL, 32'hE);
    wr(`FLM_ADR_IRQS, 32'hF);
    wr(`FLM_ADR_IRQM, 32'h4);
    drv(1'b1, 1'b0, 1'b0, 1'b0);
    chk_pin({3'h0, irq}, 4'h1);
    rdc(`FLM_ADR_IRQS, 32'h4);
    wr(`FLM_ADR_IRQM, 32'h0);
    repeat (3) @(posedge mclk);
    chk_pin({3'h0, irq}, 4'h0);
    wr(`FLM_ADR_IRQM, 32'h4);
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    chk_pin({3'h0, irq}, 4'h1);
    wr(`FLM_ADR_IRQS, 32'h4);
    repeat (3) @(posedge mclk);
    chk_pin({3'h0, irq}, 4'h0);
    // Master reset clears software state and blocks writes while low.
    wr(`FLM_ADR_CTRL, 32'h2E);
    wr(`FLM_ADR_LEVEL, 32'h25);
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    chk_pin(mode_state, 4'h4);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (8) @(posedge mclk);
    chk_pin(mode_state, 4'h1);
    chk_pin({1'b0, s3, s2, s1}, 4'h0);
    wr(`FLM_ADR_LEVEL, 32'h77);
    rdc(`FLM_ADR_LEVEL, 32'h0);
    rdc(`FLM_ADR_CTRL, 32'hE);
    @(posedge mclk);
    nrst <= 1'b1;
    repeat (8) @(posedge mclk);
    wr(`FLM_ADR_LEVEL, 32'h3);
    rdc(`FLM_ADR_LEVEL, 32'h3);
    report_and_stop();
  end
endmodule : flm_top_tb
`default_nettype wire
